// >>> logic/reset_timer_brownout_sequencer.sv
// Reset latch, device reset timer and brown-out sequencing for the chip
// Function
// - Power-up sets latch, clears reset timer
// - Timer starts on pin high, ends latch
// - Processor held while reset timer runs
// - Timer counts dedicated internal RC oscillator
// - Watchdog, pin, wake, brown-out retrigger timer
// - RC mode: 1 ms after first; else 18
// - Falling supply alone gives no reset
// - Sustained dip below trip resets chip
// - Hold until voltage recovers, then timer
// - Dip during timing restarts full period
// - Software enables detector; power-up clears it
// - Detector watches core regulated voltage
// - Trip level follows selected regulation setting
// - Run and sleep levels each have their own level bit
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module reset_timer_brownout_sequencer
    import reset_seq_pkg::*;
#(
    parameter int LONG_TICKS = DRT_LONG_TICKS,
    parameter int SHORT_TICKS = DRT_SHORT_TICKS,
    parameter int BOD_CYCLES = BOD_MIN_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata,
    input wire logic external_reset_pin_n,
    input wire logic rc_osc_clk,
    input wire logic core_below_trip_5v,
    input wire logic core_below_trip_3v,
    input wire logic [1:0] osc_mode,
    input wire logic watchdog_timeout,
    input wire logic pin_change_wake,
    output logic chip_reset,
    output logic regulation_level_5v,
    output logic sleep_level_5v,
    output logic soft_watchdog_enable,
    output logic pin_change_wake_enable
);

    logic [3:0] sync_out;
    logic pin_high;
    logic rc_level;
    logic below_5v;
    logic below_3v;
    logic rc_prev;
    logic rc_tick;
    logic [OPT_W-1:0] second_option_register;
    logic reset_latch;
    logic later_reset;
    logic use_short;
    seq_state_e state;
    seq_state_e next_state;
    reset_cause_e cause;
    logic [DRT_W-1:0] period;
    logic [DRT_W-1:0] timer_count;
    logic timer_running;
    logic timer_done;
    logic retrigger;
    reset_cause_e trigger_cause;
    logic voltage_ok;
    logic reg_wr;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] next_rdata;

    bod_if bod ();

    generate
        if (LONG_TICKS < 1 || LONG_TICKS >= (1 << DRT_W)) begin : g_long_check
            $error("LONG_TICKS does not fit the reset timer");
        end
        if (SHORT_TICKS < 1 || SHORT_TICKS >= (1 << DRT_W)) begin : g_short_check
            $error("SHORT_TICKS does not fit the reset timer");
        end
    endgenerate

    // Pin, RC oscillator and comparator levels come from outside the clock domain
    sync_2ff #(
        .WIDTH(4)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({core_below_trip_3v, core_below_trip_5v, rc_osc_clk, external_reset_pin_n}),
        .sync_out(sync_out)
    );

    assign pin_high = sync_out[0];
    assign rc_level = sync_out[1];
    assign below_5v = sync_out[2];
    assign below_3v = sync_out[3];

    // Rising edges of the internal RC oscillator pace the reset timer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rc_prev <= 1'b0;
        end else begin
            rc_prev <= rc_level;
        end
    end

    assign rc_tick = rc_level && !rc_prev;

    // Brown-out detector watches the core rail at the selected trip level
    assign bod.enable = second_option_register[OPT_BOD_EN];
    assign bod.below = second_option_register[OPT_REG_LVL] ? below_5v : below_3v;

    brownout_filter #(
        .MIN_CYCLES(BOD_CYCLES)
    ) u_bod (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bod(bod)
    );

    // Voltage counts as recovered once above trip, or always while detection is off
    assign voltage_ok = !bod.enable || !bod.below;

    // Second option register
    assign reg_wr = wr_en && (addr == OFS_SECOND_OPTION_REGISTER);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            second_option_register <= SECOND_OPTION_REGISTER_RESET;
        end else if (reg_wr) begin
            second_option_register <= wdata[OPT_W-1:0];
        end
    end

    // Option bits driven to the regulators and neighbouring blocks
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            regulation_level_5v <= SECOND_OPTION_REGISTER_RESET[OPT_REG_LVL];
            sleep_level_5v <= SECOND_OPTION_REGISTER_RESET[OPT_SLEEP_LVL];
            soft_watchdog_enable <= SECOND_OPTION_REGISTER_RESET[OPT_SWDT_EN];
            pin_change_wake_enable <= SECOND_OPTION_REGISTER_RESET[OPT_PCWU];
        end else begin
            regulation_level_5v <= second_option_register[OPT_REG_LVL];
            sleep_level_5v <= second_option_register[OPT_SLEEP_LVL];
            soft_watchdog_enable <= second_option_register[OPT_SWDT_EN];
            pin_change_wake_enable <= second_option_register[OPT_PCWU];
        end
    end

    // Reset sources while running, brown-out first
    always_comb begin
        retrigger = 1'b0;
        trigger_cause = CAUSE_POWER_UP;
        if (bod.active) begin
            retrigger = 1'b1;
            trigger_cause = CAUSE_BROWNOUT;
        end else if (!pin_high) begin
            retrigger = 1'b1;
            trigger_cause = CAUSE_PIN;
        end else if (watchdog_timeout) begin
            retrigger = 1'b1;
            trigger_cause = CAUSE_WATCHDOG;
        end else if (pin_change_wake) begin
            retrigger = 1'b1;
            trigger_cause = CAUSE_PIN_WAKE;
        end
    end

    assign timer_running = (state == SEQ_TIMING);
    assign timer_done = timer_running && rc_tick && (timer_count == period - 1'b1);

    // Sequencer; falling supply is noticed only through the brown-out detector
    always_comb begin
        next_state = state;
        case (state)
            SEQ_POR_WAIT: begin
                if (pin_high) begin
                    next_state = SEQ_TIMING;
                end
            end
            SEQ_TIMING: begin
                if (bod.active || !pin_high) begin
                    next_state = SEQ_HOLD;
                end else if (timer_done) begin
                    next_state = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (retrigger) begin
                    next_state = SEQ_HOLD;
                end
            end
            SEQ_HOLD: begin
                if (pin_high && voltage_ok && !bod.active) begin
                    next_state = SEQ_TIMING;
                end
            end
            default: begin
                next_state = SEQ_POR_WAIT;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= SEQ_POR_WAIT;
        end else begin
            state <= next_state;
        end
    end

    // Last reset cause
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cause <= CAUSE_POWER_UP;
        end else if (state == SEQ_RUN && retrigger) begin
            cause <= trigger_cause;
        end else if (state == SEQ_TIMING && bod.active) begin
            cause <= CAUSE_BROWNOUT;
        end else if (state == SEQ_TIMING && !pin_high) begin
            cause <= CAUSE_PIN;
        end
    end

    // Marks that the power-up period has been served
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            later_reset <= 1'b0;
        end else if (timer_done) begin
            later_reset <= 1'b1;
        end
    end

    assign use_short = later_reset && (osc_mode == OSC_EXTERNAL_RESISTOR_CAP);

    // Period is picked each time the timer is started
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            period <= LONG_TICKS[DRT_W-1:0];
        end else if (state != SEQ_TIMING && next_state == SEQ_TIMING) begin
            period <= use_short ? SHORT_TICKS[DRT_W-1:0] : LONG_TICKS[DRT_W-1:0];
        end
    end

    // Device reset timer counts only while timing, cleared otherwise
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            timer_count <= '0;
        end else if (next_state != SEQ_TIMING || state != SEQ_TIMING) begin
            timer_count <= '0;
        end else if (rc_tick) begin
            timer_count <= timer_count + 1'b1;
        end
    end

    // Reset latch: set by power-up and every retrigger, cleared when the timer ends
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reset_latch <= 1'b1;
        end else if (next_state == SEQ_HOLD) begin
            reset_latch <= 1'b1;
        end else if (timer_done) begin
            reset_latch <= 1'b0;
        end
    end

    // Chip reset from the next state so the output leaves its flop on time
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            chip_reset <= 1'b1;
        end else begin
            chip_reset <= (next_state != SEQ_RUN) || bod.active;
        end
    end

    // Status word
    always_comb begin
        status_word = '0;
        status_word[ST_CHIP_RESET] = chip_reset;
        status_word[ST_LATCH] = reset_latch;
        status_word[ST_TIMER_RUN] = timer_running;
        status_word[ST_BOD_ACTIVE] = bod.active;
        status_word[ST_LATER] = later_reset;
        status_word[ST_STATE_LSB +: 2] = state;
    end

    // Read data one cycle after the strobe, zero otherwise
    always_comb begin
        next_rdata = '0;
        if (rd_en) begin
            case (addr)
                OFS_SECOND_OPTION_REGISTER: begin
                    next_rdata = {{(DATA_W-OPT_W){1'b0}}, second_option_register};
                end
                OFS_STATUS: begin
                    next_rdata = status_word;
                end
                OFS_CAUSE: begin
                    next_rdata = {5'h00, cause};
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule : reset_timer_brownout_sequencer

`default_nettype wire

// >>> logic/reset_seq_pkg.sv
// Constants, field layouts and enumerations shared by the reset sequencer
package reset_seq_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_SECOND_OPTION_REGISTER = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CAUSE = 4'h8;

    // Second option register fields
    localparam int OPT_W = 6;
    localparam int OPT_BOD_EN = 0;
    localparam int OPT_BOD_LOG = 1;
    localparam int OPT_SLEEP_LVL = 2;
    localparam int OPT_REG_LVL = 3;
    localparam int OPT_SWDT_EN = 4;
    localparam int OPT_PCWU = 5;
    // Power-up value: all ones except the brown-out enable
    localparam logic [OPT_W-1:0] SECOND_OPTION_REGISTER_RESET = 6'h3E;

    // Status register fields
    localparam int ST_CHIP_RESET = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_TIMER_RUN = 2;
    localparam int ST_BOD_ACTIVE = 3;
    localparam int ST_LATER = 4;
    localparam int ST_STATE_LSB = 5;

    // Timing
    localparam int CLK_MHZ = 40;
    localparam int RC_OSC_KHZ = 1000;
    localparam int DRT_LONG_US = 18000;
    localparam int DRT_SHORT_US = 1000;
    localparam int BOD_MIN_NS = 100000;
    localparam int DRT_LONG_TICKS = DRT_LONG_US * RC_OSC_KHZ / 1000;
    localparam int DRT_SHORT_TICKS = DRT_SHORT_US * RC_OSC_KHZ / 1000;
    localparam int BOD_MIN_CYCLES = (BOD_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int DRT_W = 16;
    localparam int BOD_W = 16;

    typedef enum logic [1:0] {
        OSC_LOW_POWER_CRYSTAL = 2'b00,
        OSC_STANDARD_CRYSTAL = 2'b01,
        OSC_HIGH_SPEED_CRYSTAL = 2'b10,
        OSC_EXTERNAL_RESISTOR_CAP = 2'b11
    } osc_mode_e;

    typedef enum logic [1:0] {
        SEQ_POR_WAIT = 2'b00,
        SEQ_TIMING = 2'b01,
        SEQ_RUN = 2'b10,
        SEQ_HOLD = 2'b11
    } seq_state_e;

    typedef enum logic [2:0] {
        CAUSE_POWER_UP = 3'b000,
        CAUSE_PIN = 3'b001,
        CAUSE_WATCHDOG = 3'b010,
        CAUSE_PIN_WAKE = 3'b011,
        CAUSE_BROWNOUT = 3'b100
    } reset_cause_e;

endpackage : reset_seq_pkg

// >>> logic/bod_if.sv
// Signals between the sequencer and its brown-out filter
`timescale 1ns/1ps
`default_nettype none

interface bod_if;
    logic enable;
    logic below;
    logic active;

    modport ctrl (
        output enable,
        output below,
        input active
    );

    modport filt (
        input enable,
        input below,
        output active
    );
endinterface : bod_if

`default_nettype wire

// >>> logic/sync_2ff.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    generate
        if (WIDTH < 1) begin : g_check
            $error("sync_2ff needs WIDTH of at least 1");
        end
    endgenerate

    // First stage feeds the second stage only
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : sync_2ff

`default_nettype wire

// >>> logic/brownout_filter.sv
// Brown-out detector: below-trip level must persist before a brown-out is declared
`timescale 1ns/1ps
`default_nettype none

module brownout_filter
    import reset_seq_pkg::*;
#(
    parameter int MIN_CYCLES = BOD_MIN_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    bod_if.filt bod
);

    logic [BOD_W-1:0] dip_count;

    generate
        if (MIN_CYCLES < 1 || MIN_CYCLES >= (1 << BOD_W)) begin : g_check
            $error("brownout_filter MIN_CYCLES out of range");
        end
    endgenerate

    // Counts how long the core voltage has stayed under the trip level
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dip_count <= '0;
        end else if (!bod.enable || !bod.below) begin
            dip_count <= '0;
        end else if (dip_count != MIN_CYCLES[BOD_W-1:0]) begin
            dip_count <= dip_count + 1'b1;
        end
    end

    // Active once the dip has outlasted the minimum duration; clears as soon as voltage recovers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bod.active <= 1'b0;
        end else if (!bod.enable || !bod.below) begin
            bod.active <= 1'b0;
        end else if (dip_count == MIN_CYCLES[BOD_W-1:0] - 1'b1) begin
            bod.active <= 1'b1;
        end
    end

endmodule : brownout_filter

`default_nettype wire

// >>> verif/supply_model.sv
// Model of the reset pin driver, the supply sag and the internal RC oscillator
`timescale 1ns/1ps
`default_nettype none
module supply_model #(
    parameter int RC_HALF_NS = 115
) (
    input wire logic pin_release,
    input wire logic [1:0] sag,
    output logic external_reset_pin_n,
    output logic rc_osc_clk,
    output logic core_below_trip_5v,
    output logic core_below_trip_3v
);
    initial begin
        rc_osc_clk = 1'b0;
        forever #(RC_HALF_NS) rc_osc_clk = ~rc_osc_clk;
    end
    assign #7 external_reset_pin_n = pin_release;
    // A deep sag trips both comparators, a mild one only the higher trip
    assign #5 core_below_trip_5v = (sag != 2'h0);
    assign #5 core_below_trip_3v = (sag == 2'h2);
endmodule : supply_model
`default_nettype wire

// >>> verif/reset_seq_props.sv
// Assertion checker for the reset sequencer ports
`timescale 1ns/1ps
`default_nettype none
module reset_seq_props
    import reset_seq_pkg::*;
#(
    parameter int BOD_CYCLES = BOD_MIN_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic external_reset_pin_n,
    input wire logic core_below_trip_5v,
    input wire logic core_below_trip_3v,
    input wire logic watchdog_timeout,
    input wire logic pin_change_wake,
    input wire logic chip_reset,
    input wire logic regulation_level_5v,
    input wire logic sleep_level_5v,
    input wire logic soft_watchdog_enable,
    input wire logic pin_change_wake_enable
);
    logic bod_en;
    logic [5:0] trig_hist;
    int below_cnt;
    wire logic [3:0] opt_bits = wdata[5:2];
    wire logic [3:0] opt_out = {pin_change_wake_enable, soft_watchdog_enable, regulation_level_5v, sleep_level_5v};
    wire logic sel_below = regulation_level_5v ? core_below_trip_5v : core_below_trip_3v;
    wire logic trig_now = !external_reset_pin_n || watchdog_timeout || pin_change_wake
        || (bod_en && (core_below_trip_5v || core_below_trip_3v));
    always_ff @(posedge ref_clk) begin
        if (!rst_n) bod_en <= 1'b0;
        else if (wr_en && addr == OFS_SECOND_OPTION_REGISTER) bod_en <= wdata[OPT_BOD_EN];
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !bod_en || !sel_below) below_cnt <= 0;
        else if (below_cnt < 255) below_cnt <= below_cnt + 1;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) trig_hist <= 6'h3F;
        else trig_hist <= {trig_hist[4:0], trig_now};
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_pin_low;
        !external_reset_pin_n [*4];
    endsequence
    sequence s_opt_write;
        wr_en && addr == OFS_SECOND_OPTION_REGISTER ##2 1'b1;
    endsequence
    a_reset_state: assert property (disable iff (1'b0) !rst_n |=> chip_reset && rdata == 8'h00)
        else $error("reset state wrong");
    a_reset_values: assert property ($rose(rst_n) |-> opt_out == 4'hF)
        else $error("option outputs wrong after reset");
    a_pin_hold: assert property (s_pin_low |-> chip_reset)
        else $error("pin low without chip reset");
    a_timer_min: assert property ($fell(chip_reset) |-> external_reset_pin_n && $past(external_reset_pin_n, 8))
        else $error("reset ended without pin high");
    a_option_out: assert property (s_opt_write |-> opt_out == $past(opt_bits, 2))
        else $error("option outputs do not follow write");
    a_bod_trip: assert property (below_cnt > BOD_CYCLES + 3 |-> chip_reset)
        else $error("sustained brown-out without reset");
    a_run_quiet: assert property (!chip_reset && trig_hist == 6'h00 && !trig_now |=> !chip_reset)
        else $error("reset without a cause");
    a_trig_reset: assert property (!chip_reset && (watchdog_timeout || pin_change_wake) |-> ##[1:2] chip_reset)
        else $error("trigger pulse did not reset");
endmodule : reset_seq_props
bind reset_timer_brownout_sequencer reset_seq_props #(.BOD_CYCLES(BOD_CYCLES)) u_reset_seq_props (.*);
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking testbench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import reset_seq_pkg::*;
    localparam int LONG = 20;
    localparam int SHORT = 4;
    localparam int RC_HALF = 115;
    logic ref_clk, rst_n, wr_en, rd_en, watchdog_timeout, pin_change_wake, pin_release, chip_reset;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, opt_model, rnd;
    logic [1:0] osc_mode, sag;
    wire logic [3:0] opt_out;
    wire logic pin_n, rc_clk, below_5v, below_3v;
    int errors, cmp_count, seed, n, mode;
    supply_model #(.RC_HALF_NS(RC_HALF)) u_supply_model (.pin_release(pin_release), .sag(sag),
        .external_reset_pin_n(pin_n), .rc_osc_clk(rc_clk), .core_below_trip_5v(below_5v),
        .core_below_trip_3v(below_3v));
    reset_timer_brownout_sequencer #(.LONG_TICKS(LONG), .SHORT_TICKS(SHORT), .BOD_CYCLES(4))
        u_reset_timer_brownout_sequencer (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .external_reset_pin_n(pin_n), .rc_osc_clk(rc_clk),
        .core_below_trip_5v(below_5v), .core_below_trip_3v(below_3v), .osc_mode(osc_mode),
        .watchdog_timeout(watchdog_timeout), .pin_change_wake(pin_change_wake), .chip_reset(chip_reset),
        .regulation_level_5v(opt_out[1]), .sleep_level_5v(opt_out[0]),
        .soft_watchdog_enable(opt_out[2]), .pin_change_wake_enable(opt_out[3]));
    task automatic test_done;
        if (errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    task automatic check_val(input logic [7:0] act, input logic [7:0] exp);
        cmp_count++;
        if (act !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : check_val
    task automatic check_rst(input logic exp);
        check_val({7'h00, chip_reset}, {7'h00, exp});
    endtask : check_rst
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        check_val(rdata, exp);
    endtask : bus_read
    task automatic pulse(input int which);
        @(posedge ref_clk);
        if (which == 0) watchdog_timeout <= 1'b1;
        else pin_change_wake <= 1'b1;
        @(posedge ref_clk);
        watchdog_timeout <= 1'b0;
        pin_change_wake <= 1'b0;
    endtask : pulse
    task automatic set_sag(input logic [1:0] s, input int c);
        @(posedge ref_clk);
        sag <= s;
        tick(c);
    endtask : set_sag
    // Reset length in clock cycles against the tick count of the model
    task automatic measure(input int ticks);
        int exp;
        exp = ticks * 2 * RC_HALF / 25;
        n = 0;
        #1;
        while (chip_reset === 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        if (n >= 3000) begin
            errors++;
            test_done();
        end else begin
            cmp_count++;
            if (n < exp - 8 || n > exp + 24) begin
                errors++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, n, exp);
            end
        end
    endtask : measure
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        rst_n = 1'b0;
        {wr_en, rd_en, watchdog_timeout, pin_change_wake, pin_release} = 5'h00;
        addr = 4'h0;
        wdata = 8'h00;
        osc_mode = 2'h0;
        sag = 2'h0;
        errors = 0;
        cmp_count = 0;
        seed = 21924;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        tick(1);
        check_val({3'h0, chip_reset, opt_out}, 8'h1F);
        bus_read(OFS_SECOND_OPTION_REGISTER, 8'h3E);
        bus_read(4'hC, 8'h00);
        tick(300);
        check_rst(1'b1);
        bus_read(OFS_STATUS, 8'h03);
        @(posedge ref_clk);
        pin_release <= 1'b1;
        measure(LONG);
        bus_read(OFS_STATUS, 8'h50);
        for (int k = 0; k < 4; k++) begin
            mode = (k + 3) % 4;
            rnd = 8'($random(seed));
            opt_model = (rnd & 8'h36) | 8'h09;
            @(posedge ref_clk);
            osc_mode <= mode[1:0];
            bus_write(OFS_SECOND_OPTION_REGISTER, (rnd & 8'hC0) | opt_model);
            bus_read(OFS_SECOND_OPTION_REGISTER, opt_model);
            check_val({4'h0, opt_out}, {4'h0, opt_model[5:2]});
            if (k < 2) pulse(k);
            else if (k == 2) begin
                @(posedge ref_clk);
                pin_release <= 1'b0;
                tick(20);
                check_rst(1'b1);
                @(posedge ref_clk);
                pin_release <= 1'b1;
            end else begin
                set_sag(2'h1, 60);
                check_rst(1'b1);
                @(posedge ref_clk);
                sag <= 2'h0;
            end
            measure(mode == 3 ? SHORT : LONG);
            bus_read(OFS_CAUSE, k == 3 ? 8'h04 : (k == 2 ? 8'h01 : 8'(k + 2)));
        end
        @(posedge ref_clk);
        osc_mode <= 2'h0;
        pulse(0);
        tick(100);
        check_rst(1'b1);
        set_sag(2'h1, 30);
        @(posedge ref_clk);
        sag <= 2'h0;
        measure(LONG);
        @(posedge ref_clk);
        sag <= 2'h1;
        repeat (2) @(posedge ref_clk);
        sag <= 2'h0;
        tick(30);
        check_rst(1'b0);
        bus_write(OFS_SECOND_OPTION_REGISTER, 8'h01);
        set_sag(2'h1, 40);
        check_rst(1'b0);
        set_sag(2'h2, 40);
        check_rst(1'b1);
        @(posedge ref_clk);
        sag <= 2'h0;
        measure(LONG);
        bus_write(OFS_SECOND_OPTION_REGISTER, 8'h08);
        set_sag(2'h2, 60);
        check_rst(1'b0);
        @(posedge ref_clk);
        sag <= 2'h0;
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus_read(OFS_SECOND_OPTION_REGISTER, 8'h3E);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
